// [hdl/fbc_defs.svh]
// Contract
// - Host ends program or erase by writing the matching verify command.
// - Host waits at least the minimum pulse time before the verify write.
// - Program and erase need a set-up write followed by an execute write.
// - Data driven only with chip select and output gate low, strobe high.
// - Supply low, bit nine at identifier voltage: bit zero selects maker or part code. Host also raises bit nine with supply high when core is below lockout.
// - Writes use supply high, select low, gate high, strobe low, valid data.
// - Address taken at strobe fall, data at strobe rise; host holds both.
`ifndef FBC_DEFS_SVH
`define FBC_DEFS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FBC_CMD_READ       8'h00
`define FBC_CMD_IDENT      8'h90
`define FBC_CMD_ERASE      8'h20
`define FBC_CMD_ERASE_VFY  8'hA0
`define FBC_CMD_PROG       8'h40
`define FBC_CMD_PROG_VFY   8'hC0
`define FBC_CMD_RESET      8'hFF

// ----------------------------------------------------------------
// widths and timing
// ----------------------------------------------------------------
`define FBC_AW             17
`define FBC_DW             8
`define FBC_CW             20
`define FBC_CLK_NS         10
`define FBC_T_SU_NS        20
`define FBC_T_WP_NS        50
`define FBC_T_WH_NS        20
`define FBC_T_ACC_NS       100
`define FBC_SYNC_LAT       4
`define FBC_PROG_MIN_NS    10000
`define FBC_ERASE_MIN_NS   10000000
`define FBC_T_SU_CYC  ((`FBC_T_SU_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_T_WP_CYC  ((`FBC_T_WP_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_T_WH_CYC  ((`FBC_T_WH_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_T_RD_CYC  (((`FBC_T_ACC_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS) \
                       + `FBC_SYNC_LAT)
`define FBC_PROG_CYC  ((`FBC_PROG_MIN_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_ERASE_CYC ((`FBC_ERASE_MIN_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`endif

// [hdl/fbc_pkg.sv]
`include "fbc_defs.svh"
package fbc_pkg;
	typedef enum logic [2:0] {
		OP_READ, OP_IDENT, OP_PROG, OP_ERASE, OP_RESET
	} fbc_op_t;

	typedef enum logic [1:0] {
		CK_WR, CK_RD, CK_WAIT, CK_END
	} fbc_kind_t;

	typedef struct packed {
		fbc_op_t                 op;
		logic [`FBC_AW-1:0]      addr;
		logic [`FBC_DW-1:0]      data;
	} fbc_req_t;

	typedef struct packed {
		logic                    err;
		logic [`FBC_DW-1:0]      data;
	} fbc_rsp_t;

	typedef struct packed {
		fbc_kind_t               kind;
		logic                    id_hv;
		logic [`FBC_AW-1:0]      addr;
		logic [`FBC_DW-1:0]      data;
	} fbc_cyc_t;
endpackage

// [hdl/fbc_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module fbc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,      // system clock
	input  wire logic         rst_n,    // synchronous-release reset
	input  wire logic         en,       // clock enable
	input  wire logic [W-1:0] din,      // asynchronous level
	output var  logic [W-1:0] dout      // filtered level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// a change is taken once the second and third stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			dout <= '0;
		end else if (en) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				dout <= s3_q;
			end
		end
	end
endmodule // fbc_sync
`default_nettype wire

// [hdl/fbc_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defs.svh"
module fbc_host import fbc_pkg::*; #(
	parameter int unsigned ERASE_MIN_CYC = `FBC_ERASE_CYC
) (
	input  wire logic               CLK_SYS,        // 100 MHz clock
	input  wire logic               RST_B,          // async reset, low
	input  wire logic               CLK_EN,         // freezes state low
	input  wire logic               REQ_VALID,      // request offered
	output var  logic               REQ_READY,      // request taken
	input  wire fbc_req_t           REQ,            // request fields
	output var  logic               RSP_VALID,      // answer pulse
	output var  fbc_rsp_t           RSP,            // answer fields
	input  wire logic               SUPPLY_HIGH,    // program supply high
	input  wire logic               CORE_ABOVE_LOCKOUT, // core supply ok
	output var  logic [`FBC_AW-1:0] ADDR_OUT,       // address pins
	output var  logic               ADDR_NINE_ID_HV,// bit nine raised
	output var  logic               CHIP_SEL_B,     // chip select
	output var  logic               OUT_GATE_B,     // output gate
	output var  logic               WR_STROBE_B,    // write strobe
	input  wire logic [`FBC_DW-1:0] DATA_IN,        // data lines in
	output var  logic [`FBC_DW-1:0] DATA_OUT,       // data lines out
	output var  logic               DATA_OE_B       // low while driving
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_PLAN, ST_WR_SU, ST_WR_LO, ST_WR_HI, ST_RD, ST_WAIT,
		ST_RSP
	} fbc_st_t;

	localparam logic [`FBC_CW-1:0] SU_LIM   = `FBC_CW'(`FBC_T_SU_CYC - 1);
	localparam logic [`FBC_CW-1:0] WP_LIM   = `FBC_CW'(`FBC_T_WP_CYC - 1);
	localparam logic [`FBC_CW-1:0] WH_LIM   = `FBC_CW'(`FBC_T_WH_CYC - 1);
	localparam logic [`FBC_CW-1:0] RD_LIM   = `FBC_CW'(`FBC_T_RD_CYC - 1);
	localparam logic [`FBC_CW-1:0] PROG_LIM = `FBC_CW'(`FBC_PROG_CYC - 1);
	localparam logic [`FBC_CW-1:0] ERA_LIM  = `FBC_CW'(ERASE_MIN_CYC - 1);

	logic                 rst_s1_q;
	logic                 rst_n;
	logic [1:0]           sup_s;
	logic [`FBC_DW-1:0]   din_s;
	logic                 writable;
	fbc_st_t              state_q;
	fbc_st_t              state_d;
	logic [2:0]           step_q;
	logic [2:0]           step_d;
	logic [`FBC_CW-1:0]   cnt_q;
	logic [`FBC_CW-1:0]   cnt_d;
	logic [`FBC_CW-1:0]   wait_lim;
	fbc_req_t             req_q;
	logic                 wr_q;
	logic                 accept;
	logic                 refuse;
	fbc_cyc_t             cyc;
	logic [`FBC_DW-1:0]   prev_wr_q;

	// ----------------------------------------------------------------
	// reset release and pin inputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else if (CLK_EN) begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	fbc_sync #(.W(`FBC_DW + 2)) u_sync (
		.clk  (CLK_SYS),
		.rst_n(rst_n),
		.en   (CLK_EN),
		.din  ({SUPPLY_HIGH, CORE_ABOVE_LOCKOUT, DATA_IN}),
		.dout ({sup_s, din_s})
	);

	// command writes only with supply high and core above lockout
	assign writable = sup_s[1] && sup_s[0];

	// ----------------------------------------------------------------
	// bus cycle plan per operation
	// ----------------------------------------------------------------
	function automatic fbc_cyc_t plan(input fbc_req_t r, input logic wr,
			input logic [2:0] st);
		fbc_cyc_t c;
		c = '{kind: CK_END, id_hv: 1'b0, addr: '0, data: '0};
		case (r.op)
		OP_READ: begin
			// select array data first so verify/ident state is left
			if (wr && st == 3'd0) begin
				c.kind = CK_WR;
				c.data = `FBC_CMD_READ;
			end else if (st == (wr ? 3'd1 : 3'd0)) begin
				c.kind = CK_RD;
				c.addr = r.addr;
			end
		end
		OP_IDENT: begin
			if (wr && st == 3'd0) begin
				c.kind = CK_WR;
				c.data = `FBC_CMD_IDENT;
			end else if (st == (wr ? 3'd1 : 3'd0)) begin
				c.kind    = CK_RD;
				c.addr[0] = r.addr[0];
				c.id_hv   = !wr;
			end
		end
		OP_PROG, OP_ERASE: begin
			case (st)
			3'd0: begin
				c.kind = CK_WR;
				c.data = (r.op == OP_PROG) ? `FBC_CMD_PROG : `FBC_CMD_ERASE;
			end
			3'd1: begin
				c.kind = CK_WR;
				c.addr = r.addr;
				c.data = (r.op == OP_PROG) ? r.data : `FBC_CMD_ERASE;
			end
			3'd2: c.kind = CK_WAIT;
			3'd3: begin
				c.kind = CK_WR;
				c.addr = r.addr;
				c.data = (r.op == OP_PROG) ? `FBC_CMD_PROG_VFY
				                           : `FBC_CMD_ERASE_VFY;
			end
			3'd4: begin
				c.kind = CK_RD;
				c.addr = r.addr;
			end
			default: c.kind = CK_END;
			endcase
		end
		OP_RESET: begin
			// a stop-timer park is left by reset as well as verify
			if (st < 3'd2) begin
				c.kind = CK_WR;
				c.data = `FBC_CMD_RESET;
			end
		end
		default: c.kind = CK_END;
		endcase
		return c;
	endfunction

	assign cyc      = plan(req_q, wr_q, step_q);
	assign wait_lim = (req_q.op == OP_PROG) ? PROG_LIM : ERA_LIM;
	assign accept   = (state_q == ST_IDLE) && CLK_EN && REQ_VALID;
	// alteration and reset need the command register alive
	assign refuse   = !writable &&
	                  (REQ.op == OP_PROG || REQ.op == OP_ERASE ||
	                   REQ.op == OP_RESET);
	// a frozen block neither takes a request nor repeats its answer
	assign REQ_READY = (state_q == ST_IDLE) && CLK_EN;
	assign RSP_VALID = (state_q == ST_RSP) && CLK_EN;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		step_d  = step_q;
		cnt_d   = cnt_q + `FBC_CW'(1);
		case (state_q)
		ST_IDLE: begin
			cnt_d  = '0;
			step_d = '0;
			if (accept) begin
				state_d = refuse ? ST_RSP : ST_PLAN;
			end
		end
		ST_PLAN: begin
			cnt_d = '0;
			case (cyc.kind)
			CK_WR:   state_d = ST_WR_SU;
			CK_RD:   state_d = ST_RD;
			CK_WAIT: state_d = ST_WAIT;
			default: state_d = ST_RSP;
			endcase
		end
		ST_WR_SU: if (cnt_q == SU_LIM) begin
			state_d = ST_WR_LO;
			cnt_d   = '0;
		end
		ST_WR_LO: if (cnt_q == WP_LIM) begin
			state_d = ST_WR_HI;
			cnt_d   = '0;
		end
		ST_WR_HI: if (cnt_q == WH_LIM) begin
			state_d = ST_PLAN;
			step_d  = step_q + 3'd1;
		end
		ST_RD: if (cnt_q == RD_LIM) begin
			state_d = ST_PLAN;
			step_d  = step_q + 3'd1;
		end
		// device stays busy while deselected; only time passes here
		ST_WAIT: if (cnt_q == wait_lim) begin
			state_d = ST_PLAN;
			step_d  = step_q + 3'd1;
		end
		ST_RSP: state_d = ST_IDLE;
		default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			step_q  <= '0;
			cnt_q   <= '0;
		end else if (CLK_EN) begin
			state_q <= state_d;
			step_q  <= step_d;
			cnt_q   <= cnt_d;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= '{op: OP_READ, addr: '0, data: '0};
			wr_q  <= 1'b0;
		end else if (CLK_EN && accept) begin
			req_q <= REQ;
			wr_q  <= writable;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ADDR_OUT        <= '0;
			ADDR_NINE_ID_HV <= 1'b0;
			CHIP_SEL_B      <= 1'b1;
			OUT_GATE_B      <= 1'b1;
			WR_STROBE_B     <= 1'b1;
			DATA_OUT        <= '0;
			DATA_OE_B       <= 1'b1;
		end else if (CLK_EN) begin
			CHIP_SEL_B  <= 1'b1;
			OUT_GATE_B  <= 1'b1;
			WR_STROBE_B <= 1'b1;
			DATA_OE_B   <= 1'b1;
			ADDR_NINE_ID_HV <= 1'b0;
			case (state_d)
			ST_WR_SU, ST_WR_LO, ST_WR_HI: begin
				CHIP_SEL_B  <= 1'b0;
				DATA_OE_B   <= 1'b0;
				WR_STROBE_B <= (state_d != ST_WR_LO);
			end
			ST_RD: begin
				CHIP_SEL_B      <= 1'b0;
				OUT_GATE_B      <= 1'b0;
				ADDR_NINE_ID_HV <= cyc.id_hv;
			end
			default: ;
			endcase
			// address and data stay put through the whole cycle
			if (state_q == ST_PLAN) begin
				ADDR_OUT <= cyc.addr;
				DATA_OUT <= cyc.data;
			end
		end
	end

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			RSP       <= '0;
			prev_wr_q <= `FBC_CMD_READ;
		end else if (CLK_EN) begin
			if (accept) begin
				RSP.err <= refuse;
			end
			if (state_q == ST_RD && cnt_q == RD_LIM) begin
				RSP.data <= din_s;
			end
			if (state_q == ST_WR_HI && cnt_q == WH_LIM) begin
				prev_wr_q <= DATA_OUT;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n || !CLK_EN);

	AST_NO_DRIVE_ON_READ: assert property (
		!OUT_GATE_B |-> DATA_OE_B && WR_STROBE_B && !CHIP_SEL_B)
		else $error("data driven during read");
	AST_WRITE_LEVELS: assert property (
		!WR_STROBE_B |-> !CHIP_SEL_B && OUT_GATE_B && !DATA_OE_B && wr_q)
		else $error("write strobe with bad levels");
	AST_ADDR_HELD: assert property (
		!WR_STROBE_B && $past(!WR_STROBE_B) |-> $stable(ADDR_OUT))
		else $error("address moved under strobe");
	AST_DATA_AT_RISE: assert property (
		$rose(WR_STROBE_B) |-> !DATA_OE_B && $stable(DATA_OUT)
		##1 !DATA_OE_B)
		else $error("data not held at strobe rise");
	AST_MIN_WAIT: assert property (
		state_q == ST_WAIT && state_d != ST_WAIT |-> cnt_q == wait_lim)
		else $error("verify issued before minimum");
	AST_TWO_STEP: assert property (
		state_q == ST_PLAN && step_q == 3'd1 && req_q.op == OP_PROG
		|-> prev_wr_q == `FBC_CMD_PROG)
		else $error("program without set-up write");
	AST_VERIFY_AFTER_WAIT: assert property (
		state_q == ST_WAIT && state_d == ST_PLAN |=> ##1 state_q == ST_WR_SU
		&& (DATA_OUT == `FBC_CMD_PROG_VFY || DATA_OUT == `FBC_CMD_ERASE_VFY))
		else $error("no verify write after pulse");
	AST_ID_PIN: assert property (
		ADDR_NINE_ID_HV |-> !wr_q && ADDR_OUT[`FBC_AW-1:1] == '0
		&& !OUT_GATE_B)
		else $error("identifier voltage with bad levels");
	AST_RSP_PULSE: assert property (
		RSP_VALID |=> !RSP_VALID && REQ_READY)
		else $error("answer longer than one cycle");

	COV_PROG: cover property (
		RSP_VALID && req_q.op == OP_PROG && !RSP.err);
	COV_ERASE: cover property (
		RSP_VALID && req_q.op == OP_ERASE && !RSP.err);
	COV_ID_PIN: cover property (ADDR_NINE_ID_HV && !OUT_GATE_B);
	COV_REFUSED: cover property (RSP_VALID && RSP.err);
endmodule // fbc_host
`default_nettype wire

// [testbench/fbc_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defs.svh"
module fbc_dev_model #(
	parameter logic [7:0]  MFR_CODE     = 8'h3C, // arbitrary value
	parameter logic [7:0]  DEV_CODE     = 8'hD2, // arbitrary value
	parameter int unsigned PROG_MIN_NS  = 10000,
	parameter int unsigned ERASE_MIN_NS = 500,
	parameter int unsigned STOP_NS      = 100000 // stop timer, arbitrary
) (
	input  wire logic               clk,       // keeps float pattern
	input  wire logic               supply_hi, // program supply high
	input  wire logic               core_ok,   // core above lockout
	input  wire logic [`FBC_AW-1:0] addr,      // address pins
	input  wire logic               id_hv,     // bit nine at id voltage
	input  wire logic               ce_b,      // chip select
	input  wire logic               oe_b,      // output gate
	input  wire logic               we_b,      // write strobe
	input  wire logic [`FBC_DW-1:0] host_data, // host data out
	input  wire logic               host_oe_b, // host drives when low
	output var  logic [`FBC_DW-1:0] line,      // resolved data lines
	output var  logic [7:0]         viol       // faults seen
);
	logic [7:0]         mem [0:255];
	logic [7:0]         cmd, last_q, dev_q, clash, bad;
	logic [`FBC_AW-1:0] wa, pa, ea;
	logic               set_p, set_e, stopped;
	realtime            t_op;
	wire                drv = !ce_b && !oe_b && we_b;

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
		cmd = `FBC_CMD_READ;
		set_p = 1'b0;
		set_e = 1'b0;
		stopped = 1'b0;
		clash = 8'h00;
		bad = 8'h00;
		last_q = 8'h00;
		t_op = 0;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always @* begin
		if (!supply_hi)
			dev_q = id_hv ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr[7:0]];
		else if (cmd == `FBC_CMD_IDENT)
			dev_q = addr[0] ? DEV_CODE : MFR_CODE;
		else if (cmd == `FBC_CMD_PROG_VFY)
			dev_q = mem[pa[7:0]];
		else if (cmd == `FBC_CMD_ERASE_VFY)
			dev_q = mem[ea[7:0]];
		else
			dev_q = mem[addr[7:0]];
	end
	// released lines show the inverse of the last driven value
	assign line = !host_oe_b ? host_data : drv ? dev_q : ~last_q;
	assign viol = clash + bad;
	always @(posedge clk) begin
		if (!host_oe_b || drv) last_q <= line;
		if (!host_oe_b && drv) clash <= clash + 8'h01;
	end

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	always @(negedge supply_hi) begin
		cmd = `FBC_CMD_READ;
		set_p = 1'b0;
		set_e = 1'b0;
	end
	always @(negedge we_b) if (!ce_b) wa = addr;
	always @(posedge we_b) begin
		if (!ce_b && supply_hi && core_ok) begin
			if (!oe_b) bad = bad + 8'h01;
			// an overlong pulse was cut by the stop timer: device parked
			stopped = (cmd == `FBC_CMD_PROG || cmd == `FBC_CMD_ERASE) &&
				($realtime - t_op >= STOP_NS);
			if (stopped && line != `FBC_CMD_PROG_VFY &&
				line != `FBC_CMD_ERASE_VFY && line != `FBC_CMD_RESET) begin
				// parked: every other command is ignored
			end else if (set_p) begin
				mem[wa[7:0]] = line;
				pa = wa;
				set_p = 1'b0;
				t_op = $realtime;
				// the pulse runs on whatever chip select does meanwhile
				cmd = `FBC_CMD_PROG;
			end else if (set_e && line == `FBC_CMD_ERASE) begin
				for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
				set_e = 1'b0;
				t_op = $realtime;
				cmd = `FBC_CMD_ERASE;
			end else begin
				set_e = 1'b0;
				case (line)
					`FBC_CMD_PROG: set_p = 1'b1;
					`FBC_CMD_ERASE: set_e = 1'b1;
					`FBC_CMD_PROG_VFY, `FBC_CMD_ERASE_VFY: begin
						if (cmd == `FBC_CMD_PROG && $realtime - t_op < PROG_MIN_NS)
							bad = bad + 8'h01;
						if (cmd == `FBC_CMD_ERASE && $realtime - t_op < ERASE_MIN_NS)
							bad = bad + 8'h01;
						ea = wa;
						cmd = line;
					end
					`FBC_CMD_RESET: cmd = (cmd == `FBC_CMD_RESET) ?
						`FBC_CMD_READ : `FBC_CMD_RESET;
					default: cmd = line;
				endcase
			end
		end
	end
endmodule // fbc_dev_model
`default_nettype wire

// [testbench/fbc_host_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defs.svh"
module fbc_host_test import fbc_pkg::*;;
	localparam logic [7:0] MFR = 8'h3C; // arbitrary value
	localparam logic [7:0] DEV = 8'hD2; // arbitrary value
	logic               clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0;
	logic               sup = 1'b0, core = 1'b1, en = 1'b1;
	fbc_req_t           req = '0;
	fbc_rsp_t           rsp, r;
	logic               req_ready, rsp_valid, id_hv, cs_b, og_b, ws_b, d_oe_b;
	logic [`FBC_AW-1:0] a_out;
	logic [7:0]         d_out, line, viol;
	int                 err_count = 0, checks = 0, cs_falls = 0, n0;

	always #5 clk = ~clk;
	always @(negedge cs_b) cs_falls++;

	fbc_host #(.ERASE_MIN_CYC(50)) fbc_host_i (.CLK_SYS(clk), .RST_B(rst_b),
		.CLK_EN(en), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
		.RSP_VALID(rsp_valid), .RSP(rsp), .SUPPLY_HIGH(sup),
		.CORE_ABOVE_LOCKOUT(core), .ADDR_OUT(a_out), .ADDR_NINE_ID_HV(id_hv),
		.CHIP_SEL_B(cs_b), .OUT_GATE_B(og_b), .WR_STROBE_B(ws_b),
		.DATA_IN(line), .DATA_OUT(d_out), .DATA_OE_B(d_oe_b));
	fbc_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROG_MIN_NS(10000),
		.ERASE_MIN_NS(500)) fbc_dev_model_i (.clk(clk), .supply_hi(sup),
		.core_ok(core), .addr(a_out), .id_hv(id_hv), .ce_b(cs_b), .oe_b(og_b),
		.we_b(ws_b), .host_data(d_out), .host_oe_b(d_oe_b), .line(line),
		.viol(viol));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xfer(fbc_op_t op, logic [16:0] a, logic [7:0] d);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{op, a, d};
		n = 0;
		@(negedge clk);
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		@(negedge clk);
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		r = rsp;
		chk("answer pulse", 9'h001, {8'h00, rsp_valid});
	endtask
	task automatic pwr(logic s, logic c);
		@(posedge clk);
		sup <= s;
		core <= c;
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_low;
		pwr(1'b0, 1'b1);
		xfer(OP_READ, 17'h00012, 8'h00);
		chk("low read", {1'b0, 8'h12 ^ 8'hA5}, r);
		xfer(OP_IDENT, 17'h00000, 8'h00);
		chk("pin maker code", {1'b0, MFR}, r);
		xfer(OP_IDENT, 17'h00001, 8'h00);
		chk("pin part code", {1'b0, DEV}, r);
		n0 = cs_falls;
		for (int k = 2; k <= 4; k++) begin
			xfer(fbc_op_t'(k), 17'h00040, 8'h00);
			chk("low refuse", 9'h100, {r.err, 8'h00});
		end
		chk("no pin activity", 9'h000, 9'(cs_falls - n0));
	endtask
	task automatic t_freeze;
		@(posedge clk);
		en <= 1'b0;
		fork
			xfer(OP_READ, 17'h00023, 8'h00);
			begin
				repeat (3) @(negedge clk);
				chk("ready while frozen", 9'h000, {8'h00, req_ready});
				@(posedge clk);
				en <= 1'b1;
			end
		join
		chk("read after freeze", {1'b0, 8'h23 ^ 8'hA5}, r);
	endtask
	task automatic t_prog;
		pwr(1'b1, 1'b1);
		xfer(OP_PROG, 17'h00040, 8'h3E);
		chk("program verify", {1'b0, 8'h3E}, r);
		xfer(OP_READ, 17'h00040, 8'h00);
		chk("program readback", {1'b0, 8'h3E}, r);
		xfer(OP_READ, 17'h00041, 8'h00);
		chk("neighbour", {1'b0, 8'h41 ^ 8'hA5}, r);
	endtask
	task automatic t_ident;
		xfer(OP_IDENT, 17'h00000, 8'h00);
		chk("cmd maker code", {1'b0, MFR}, r);
		xfer(OP_IDENT, 17'h00001, 8'h00);
		chk("cmd part code", {1'b0, DEV}, r);
		pwr(1'b0, 1'b1);
		xfer(OP_READ, 17'h00001, 8'h00);
		chk("array after drop", {1'b0, 8'h01 ^ 8'hA5}, r);
	endtask
	task automatic t_erase;
		pwr(1'b1, 1'b1);
		xfer(OP_ERASE, 17'h00007, 8'h00);
		chk("erase verify", 9'h0FF, r);
		xfer(OP_READ, 17'h00040, 8'h00);
		chk("erased read", 9'h0FF, r);
	endtask
	task automatic t_lock;
		pwr(1'b1, 1'b0);
		n0 = cs_falls;
		xfer(OP_PROG, 17'h00010, 8'h00);
		chk("lockout refuse", 9'h100, {r.err, 8'h00});
		chk("lockout pins", 9'h000, 9'(cs_falls - n0));
		pwr(1'b1, 1'b1);
		xfer(OP_RESET, 17'h00000, 8'h00);
		chk("reset taken", 9'h000, {r.err, 8'h00});
		xfer(OP_READ, 17'h00010, 8'h00);
		chk("read after reset", 9'h0FF, r);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (10) @(posedge clk);
		t_low();
		t_freeze();
		t_prog();
		t_ident();
		t_erase();
		t_lock();
		chk("far side faults", 9'h000, {1'b0, viol});
		stop_test();
	end
endmodule // fbc_host_test
`default_nettype wire
